/* File: design/hrp_params.svh */
// constants for the hardware response port: offsets, fields, resets, timing
// assumes a 125 MHz apb clock and byte addresses on the apb bus
// Behaviour
// - ports come in 1 to 32 bits; all pins of one port share a direction.
// - open collector: a zero pulls low, a one leaves the pin undriven.
// - port drives pins or samples them, sampling optionally held for a condition.
// - each processor access to a port completes in one cycle.
// - output data passes a 4-word fifo plus transfer register; input samples pass the fifo only.
// - each port has a 16-bit counter timing pin transfers.
// - counter readable anytime; a transfer can wait for a future count.
// - every transfer captures the counter as a timestamp for software.
// - an enabled inter-chip link disconnects the ports on its pins.
// - an enabled narrower port takes shared pins from wider ports.
// - unshared pins of the wider port stay usable.
// - a port always transfers at its nominal width.
// - six clock blocks; block 0 is the 100 MHz reference, others programmable.
// - a clock block can take a 1-bit port clock, optionally divided.
// - ports accept an input ready strobe and make an output ready strobe.
// - after reset every port runs from clock block 0.
// - pin events go straight to the tile event scheduler.
// - all general pins have pull-down on while in reset.
`ifndef HRP_PARAMS_SVH
`define HRP_PARAMS_SVH

`define HRP_ADDR_CTRL   8'h00
`define HRP_ADDR_COND   8'h04
`define HRP_ADDR_TIME   8'h08
`define HRP_ADDR_DATA   8'h0c
`define HRP_ADDR_COUNT  8'h10
`define HRP_ADDR_STAMP  8'h14
`define HRP_ADDR_STATUS 8'h18
`define HRP_ADDR_CLKB   8'h20

`define HRP_CTRL_EN     0
`define HRP_CTRL_OUT    1
`define HRP_CTRL_OC     2
`define HRP_CTRL_CB     3
`define HRP_CTRL_CONDEN 6
`define HRP_CTRL_CONDNE 7
`define HRP_CTRL_RDYIN  8
`define HRP_CTRL_RDYOUT 9
`define HRP_CTRL_BITS   10
`define HRP_CTRL_RESET  10'h000
`define HRP_CLKB_SRC    8
`define HRP_CLKB_RESET  9'h000

`define HRP_NUM_CB      6
`define HRP_CLK_HZ      28'd125000000
`define HRP_REF_HZ      28'd100000000

`endif

/* File: design/hrp_pkg.sv */
// types for the hardware response port
// assumes hrp_params.svh holds all numeric constants
package hrp_pkg;
    typedef enum logic [0:0] {HRP_EMPTY, HRP_LOADED} hrp_xfer_type;
endpackage

/* File: design/hrp_port.sv */
// hardware response port: apb registers, six clock blocks, 4-word fifo,
// transfer register, port counter, timestamps and pin sharing
// assumes pins, ready strobe and external clock are asynchronous to pclk;
// link_active and narrow_claim come from logic on pclk
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"

module hrp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    // depth must be a power of two so the pointers wrap by themselves
    always_comb begin
        in_ready    = (count != DEPTH[AW:0]);
        out_valid   = (count != '0);
        out_data    = mem[rd_ptr];
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage has no reset; empty flag guards every read
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

module hrp_port #(
    parameter int WIDTH = 32
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic                  pulldown_en,
    input  wire logic             clk_pin_in,
    input  wire logic             input_ready_strobe,
    output logic                  output_ready_strobe,
    input  wire logic             link_active,
    input  wire logic [WIDTH-1:0] narrow_claim,
    output logic                  port_event
);
    localparam int NCB = `HRP_NUM_CB;

    // clock blocks
    logic [27:0] ref_acc, next_ref_acc;
    logic        ref_tick, next_ref_tick;
    logic        ext_s1, ext_s2, ext_s3;
    logic        ext_rise;
    logic [8:0]  cb_cfg [1:NCB-1];
    logic [7:0]  cb_cnt [1:NCB-1];
    logic [7:0]  next_cb_cnt [1:NCB-1];
    logic [NCB-1:0] cb_tick, next_cb_tick;

    // port state
    logic [`HRP_CTRL_BITS-1:0] ctrl, next_ctrl;
    logic [8:0]       next_cb_cfg [1:NCB-1];
    logic [WIDTH-1:0] cond_val, next_cond_val;
    logic [15:0]      time_val, next_time_val;
    logic             timed, next_timed;
    logic [15:0]      count, next_count;
    logic [15:0]      stamp, next_stamp;
    logic [WIDTH-1:0] xfer, next_xfer;
    logic [WIDTH-1:0] out_reg, next_out_reg;
    hrp_pkg::hrp_xfer_type xst, next_xst;
    logic             rdy_out, next_rdy_out;
    logic             evt, next_evt;
    logic             pd, next_pd;
    logic [WIDTH-1:0] pin_s1, pin_s2;
    logic             rdy_s1, rdy_s2;

    // bus and fifo glue
    logic             wr_acc, rd_acc, unmapped;
    logic             tick, dir_out, time_ok, cond_ok, xfer_fire, sample_fire;
    logic             f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [WIDTH-1:0] f_in_data, f_out_data, cedes;
    logic [2:0]       cb_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            rdy_s1 <= input_ready_strobe;
            rdy_s2 <= rdy_s1;
            ext_s1 <= clk_pin_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // block 0 paces 100 MHz from 125 MHz by fractional accumulation
    always_comb begin
        ext_rise = ext_s2 & ~ext_s3;
        next_ref_tick = (ref_acc + `HRP_REF_HZ >= `HRP_CLK_HZ);
        next_ref_acc  = next_ref_tick ? ref_acc + `HRP_REF_HZ - `HRP_CLK_HZ : ref_acc + `HRP_REF_HZ;
        next_cb_tick[0] = next_ref_tick;
        for (int n = 1; n < NCB; n++) begin
            next_cb_cnt[n]  = cb_cnt[n];
            next_cb_tick[n] = 1'b0;
            if (cb_cfg[n][`HRP_CLKB_SRC] ? ext_rise : ref_tick) begin
                if (cb_cnt[n] >= cb_cfg[n][7:0]) begin
                    next_cb_cnt[n]  = '0;
                    next_cb_tick[n] = 1'b1;
                end else begin
                    next_cb_cnt[n] = cb_cnt[n] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_acc  <= '0;
            ref_tick <= 1'b0;
            cb_tick  <= '0;
            for (int n = 1; n < NCB; n++) begin
                cb_cnt[n] <= '0;
            end
        end else begin
            ref_acc  <= next_ref_acc;
            ref_tick <= next_ref_tick;
            cb_tick  <= next_cb_tick;
            for (int n = 1; n < NCB; n++) begin
                cb_cnt[n] <= next_cb_cnt[n];
            end
        end
    end

    hrp_fifo #(.WIDTH(WIDTH), .DEPTH(4)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb begin
        wr_acc   = psel & penable & pwrite;
        rd_acc   = psel & penable & ~pwrite;
        unmapped = (paddr > `HRP_ADDR_STATUS && paddr < `HRP_ADDR_CLKB)
                 || paddr > `HRP_ADDR_CLKB + 8'h10 || paddr[1:0] != 2'b00;
        dir_out  = ctrl[`HRP_CTRL_OUT];
        cb_sel   = ctrl[`HRP_CTRL_CB +: 3];
        tick     = ctrl[`HRP_CTRL_EN] & (cb_sel < 3'd6) & cb_tick[cb_sel];
        time_ok  = ~timed | (count == time_val);
        cond_ok  = ~ctrl[`HRP_CTRL_CONDEN]
                 | ((pin_s2 == cond_val) ^ ctrl[`HRP_CTRL_CONDNE]);
        xfer_fire   = tick & dir_out & (xst == hrp_pkg::HRP_LOADED) & time_ok;
        // a full fifo stalls sampling rather than losing words
        sample_fire = tick & ~dir_out & time_ok & cond_ok & f_in_ready
                    & (~ctrl[`HRP_CTRL_RDYIN] | rdy_s2);
        f_in_valid  = dir_out ? (wr_acc & paddr == `HRP_ADDR_DATA) : sample_fire;
        f_in_data   = dir_out ? pwdata[WIDTH-1:0] : pin_s2;
        f_out_ready = dir_out ? (xst == hrp_pkg::HRP_EMPTY)
                              : (rd_acc & paddr == `HRP_ADDR_DATA);
        pready  = 1'b1;
        pslverr = psel & penable & (unmapped
                | (paddr == `HRP_ADDR_DATA & pwrite & ~(dir_out & f_in_ready))
                | (paddr == `HRP_ADDR_DATA & ~pwrite & ~(~dir_out & f_out_valid)));
        prdata = '0;
        case (paddr)
            `HRP_ADDR_CTRL:   prdata[`HRP_CTRL_BITS-1:0] = ctrl;
            `HRP_ADDR_COND:   prdata[WIDTH-1:0] = cond_val;
            `HRP_ADDR_TIME:   prdata[15:0] = time_val;
            `HRP_ADDR_DATA:   prdata[WIDTH-1:0] = dir_out ? '0 : f_out_data;
            `HRP_ADDR_COUNT:  prdata[15:0] = count;
            `HRP_ADDR_STAMP:  prdata[15:0] = stamp;
            `HRP_ADDR_STATUS: prdata[3:0] = {timed, xst == hrp_pkg::HRP_LOADED, f_in_ready, f_out_valid};
            default: begin
                for (int n = 1; n < NCB; n++) begin
                    if (paddr == `HRP_ADDR_CLKB + 8'(4 * (n - 1))) begin
                        prdata[8:0] = cb_cfg[n];
                    end
                end
            end
        endcase
    end

    always_comb begin
        next_ctrl     = ctrl;
        next_cond_val = cond_val;
        next_time_val = time_val;
        next_timed    = timed;
        next_xfer     = xfer;
        next_xst      = xst;
        next_out_reg  = out_reg;
        next_stamp    = stamp;
        next_rdy_out  = 1'b0;
        next_evt      = 1'b0;
        next_pd       = 1'b0;
        next_count    = tick ? count + 16'h0001 : count;
        for (int n = 1; n < NCB; n++) begin
            next_cb_cfg[n] = cb_cfg[n];
        end
        if (xfer_fire | sample_fire) begin
            next_timed = 1'b0;
            next_stamp = count;
        end
        if (xfer_fire) begin
            next_out_reg = xfer;
            next_xst     = hrp_pkg::HRP_EMPTY;
            next_rdy_out = ctrl[`HRP_CTRL_RDYOUT];
        end
        if (sample_fire) begin
            next_evt = 1'b1;
        end
        if (f_out_valid & f_out_ready & dir_out) begin
            next_xfer = f_out_data;
            next_xst  = hrp_pkg::HRP_LOADED;
        end
        if (wr_acc) begin
            case (paddr)
                `HRP_ADDR_CTRL: next_ctrl = pwdata[`HRP_CTRL_BITS-1:0];
                `HRP_ADDR_COND: next_cond_val = pwdata[WIDTH-1:0];
                `HRP_ADDR_TIME: begin
                    next_time_val = pwdata[15:0];
                    next_timed    = 1'b1; // arming wins over a same-cycle transfer
                end
                default: begin
                    for (int n = 1; n < NCB; n++) begin
                        if (paddr == `HRP_ADDR_CLKB + 8'(4 * (n - 1))) begin
                            next_cb_cfg[n] = pwdata[8:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= `HRP_CTRL_RESET;
            cond_val <= '0;
            time_val <= '0;
            timed    <= 1'b0;
            count    <= '0;
            stamp    <= '0;
            xfer     <= '0;
            xst      <= hrp_pkg::HRP_EMPTY;
            out_reg  <= '0;
            rdy_out  <= 1'b0;
            evt      <= 1'b0;
            pd       <= 1'b1;
            for (int n = 1; n < NCB; n++) begin
                cb_cfg[n] <= `HRP_CLKB_RESET;
            end
        end else begin
            ctrl     <= next_ctrl;
            cond_val <= next_cond_val;
            time_val <= next_time_val;
            timed    <= next_timed;
            count    <= next_count;
            stamp    <= next_stamp;
            xfer     <= next_xfer;
            xst      <= next_xst;
            out_reg  <= next_out_reg;
            rdy_out  <= next_rdy_out;
            evt      <= next_evt;
            pd       <= next_pd;
            for (int n = 1; n < NCB; n++) begin
                cb_cfg[n] <= next_cb_cfg[n];
            end
        end
    end

    // pins claimed by a narrower port are released bit by bit; an active link releases every pin
    always_comb begin
        cedes = narrow_claim | {WIDTH{link_active}};
        for (int b = 0; b < WIDTH; b++) begin
            pin_oe[b] = ctrl[`HRP_CTRL_EN] & dir_out & ~cedes[b]
                      & ~(ctrl[`HRP_CTRL_OC] & out_reg[b]);
            pin_out[b] = ~ctrl[`HRP_CTRL_OC] & out_reg[b];
        end
        output_ready_strobe = rdy_out;
        port_event  = evt;
        pulldown_en = pd;
    end

    sequence s_sample_taken;
        sample_fire ##1 port_event;
    endsequence

    a_dir_single: assert property (@(posedge pclk) disable iff (!presetn)
        !dir_out |-> pin_oe == '0) else $error("input port drives its pins");
    a_oc_no_high: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[`HRP_CTRL_OC] |-> (pin_oe & out_reg) == '0) else $error("open collector drives high");
    a_cond_hold: assert property (@(posedge pclk) disable iff (!presetn)
        sample_fire & ctrl[`HRP_CTRL_CONDEN] & ~ctrl[`HRP_CTRL_CONDNE] |-> pin_s2 == cond_val)
        else $error("sample taken before condition met");
    a_apb_single: assert property (@(posedge pclk) disable iff (!presetn)
        psel & !penable ##1 psel & penable |-> pready) else $error("access not single cycle");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> count == 16'($past(count) + 16'h0001)) else $error("counter step wrong");
    a_count_still: assert property (@(posedge pclk) disable iff (!presetn)
        !tick |=> $stable(count)) else $error("counter moved without a tick");
    a_time_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_fire | sample_fire) & timed |-> count == time_val) else $error("timed transfer early");
    a_stamp_take: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_fire |=> stamp == $past(count) && pin_out == ($past(xfer) & ~{WIDTH{ctrl[`HRP_CTRL_OC]}}))
        else $error("timestamp or output not taken");
    a_pin_cede: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_oe & (narrow_claim | {WIDTH{link_active}})) == '0) else $error("shared pin still driven");
    a_ready_out: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_fire & ctrl[`HRP_CTRL_RDYOUT] |=> output_ready_strobe ##1 !output_ready_strobe)
        else $error("output ready strobe wrong");
    a_event_fwd: assert property (@(posedge pclk) disable iff (!presetn)
        sample_fire |-> s_sample_taken) else $error("pin event not forwarded");
endmodule

`default_nettype wire

/* File: sim/hrp_pins_model.sv */
// pin-side model: external hardware on the port pins, clock pin and ready strobe
// assumes the bench steers ext_en, ext_val and rdy_level and calls burst
`timescale 1ns/1ps
`default_nettype none

module hrp_pins_model #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe,
    input  wire logic             pulldown_en,
    input  wire logic             ext_en,
    input  wire logic [WIDTH-1:0] ext_val,
    input  wire logic             rdy_level,
    output logic      [WIDTH-1:0] pin_in,
    output logic                  clk_pin_in,
    output logic                  input_ready_strobe
);
    // undriven pins float up by a board pull-up, down while the device is in reset
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en)
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = !pulldown_en;
        end
    end

    assign input_ready_strobe = rdy_level;

    initial clk_pin_in = 1'b0;

    // clock stands low between bursts; 40 ns period, five pclk periods, so each edge keeps one phase to pclk
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            #13 clk_pin_in = 1'b1;
            #27 clk_pin_in = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: sim/tb_hw_response_port_clocking.sv */
// self-checking bench for hrp_port: apb tasks, random data, corner cases
// assumes hrp_port at WIDTH 8 with hrp_pins_model on its pin side
`timescale 1ns/1ps
`default_nettype none
`include "hrp_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end

module tb_hw_response_port_clocking;
    localparam int          W     = 8;
    localparam logic [31:0] C_EN  = 32'h1 << `HRP_CTRL_EN;
    localparam logic [31:0] C_OUT = 32'h1 << `HRP_CTRL_OUT;
    localparam logic [31:0] C_OC  = 32'h1 << `HRP_CTRL_OC;
    localparam logic [31:0] C_CB1 = 32'h1 << `HRP_CTRL_CB;
    localparam logic [31:0] C_CE  = 32'h1 << `HRP_CTRL_CONDEN;
    localparam logic [31:0] C_RI  = 32'h1 << `HRP_CTRL_RDYIN;
    localparam logic [31:0] C_RO  = 32'h1 << `HRP_CTRL_RDYOUT;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic         pulldown_en, clk_pin_in, input_ready_strobe, output_ready_strobe;
    logic         link_active, port_event, ext_en, rdy_level;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rdata, seed;
    logic [W-1:0] pin_in, pin_out, pin_oe, narrow_claim, ext_val, v, c;
    logic [15:0]  cnt, tgt;
    logic [31:0]  q [5];
    int           checks, fail_count, slow, cycles;

    hrp_port #(.WIDTH(W)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pulldown_en, .clk_pin_in, .input_ready_strobe,
        .output_ready_strobe, .link_active, .narrow_claim, .port_event);
    hrp_pins_model #(.WIDTH(W)) i_model (.pin_out, .pin_oe, .pulldown_en, .ext_en, .ext_val,
        .rdy_level, .pin_in, .clk_pin_in, .input_ready_strobe);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // open collector drives only zeros; claimed pins and an active link release
    function automatic logic [W-1:0] exp_oe(logic oc, logic [W-1:0] d, logic [W-1:0] cl, logic lk);
        logic [W-1:0] m;
        m = lk ? '0 : ~cl;
        return oc ? (m & ~d) : m;
    endfunction

    task automatic conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // sampled at the rising edge that completes the access
        do begin
            @(posedge pclk);
            rdy = pready;
            r = prdata;
            e = pslverr;
            if (rdy !== 1'b1) slow++;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, rdata, err);
        `CHK(err, ee)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic ee);
        apb(1'b0, a, 32'h0, rdata, err);
        `CHK(err, ee)
        if (!ee) `CHK(rdata & m, e)
    endtask

    // pulses last one cycle, so every cycle is looked at
    task automatic wait_pulse(input logic ev);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (((ev ? port_event : output_ready_strobe) !== 1'b1) && n < 400);
        `CHK(n < 400, 1'b1)
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        seed = 32'h1f7d;
        {presetn, psel, penable, pwrite, link_active, ext_en} = '0;
        {paddr, pwdata, narrow_claim, ext_val} = '0;
        rdy_level = 1'b1;
        repeat (5) @(posedge pclk);
        `CHK({pulldown_en, pin_oe}, {1'b1, 8'h00})
        presetn <= 1'b1;
        rd_chk(`HRP_ADDR_CTRL, 32'h0, 32'h3ff, 1'b0);
        rd_chk(`HRP_ADDR_COUNT, 32'h0, 32'hffff, 1'b0);
        `CHK(pulldown_en, 1'b0)
        rd_chk(8'h1c, 32'h0, 32'h0, 1'b1);
        rd_chk(8'h34, 32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            q[i] = rnd() & 32'h1ff;
            rd_chk(`HRP_ADDR_CLKB + 8'(4 * i), 32'h0, 32'h1ff, 1'b0);
            wr_chk(`HRP_ADDR_CLKB + 8'(4 * i), q[i], 1'b0);
            rd_chk(`HRP_ADDR_CLKB + 8'(4 * i), q[i], 32'h1ff, 1'b0);
        end
        // external clock held still, so the buffer fills until it refuses
        wr_chk(`HRP_ADDR_CLKB, 32'h100, 1'b0);
        wr_chk(`HRP_ADDR_CTRL, C_EN | C_OUT | C_CB1 | C_RO, 1'b0);
        for (int i = 0; i < 5; i++) begin
            q[i] = rnd();
            wr_chk(`HRP_ADDR_DATA, q[i], 1'b0);
        end
        wr_chk(`HRP_ADDR_DATA, 32'h0, 1'b1);
        rd_chk(`HRP_ADDR_STATUS, 32'h5, 32'hf, 1'b0);
        fork
            i_model.burst(5);
            for (int i = 0; i < 5; i++) begin
                wait_pulse(1'b0);
                `CHK({pin_out, pin_oe}, {q[i][W-1:0], 8'hff})
            end
        join
        rd_chk(`HRP_ADDR_STATUS, 32'h2, 32'hf, 1'b0);
        rd_chk(`HRP_ADDR_COUNT, 32'h5, 32'hffff, 1'b0);
        // reference block ticks 4 of every 5 cycles; 50 cycles gap
        wr_chk(`HRP_ADDR_CTRL, C_EN | C_OUT | C_RO, 1'b0);
        rd_chk(`HRP_ADDR_COUNT, 32'h0, 32'h0, 1'b0);
        cnt = rdata[15:0];
        repeat (47) @(posedge pclk);
        tgt = cnt + 16'd40;
        rd_chk(`HRP_ADDR_COUNT, {16'h0, tgt}, 32'hffff, 1'b0);
        v = W'(rnd());
        tgt = tgt + 16'd100;
        wr_chk(`HRP_ADDR_TIME, {16'h0, tgt}, 1'b0);
        wr_chk(`HRP_ADDR_DATA, {24'h0, v}, 1'b0);
        wait_pulse(1'b0);
        `CHK(pin_out, v)
        rd_chk(`HRP_ADDR_STAMP, {16'h0, tgt}, 32'hffff, 1'b0);
        wr_chk(`HRP_ADDR_CTRL, C_EN | C_OUT | C_OC | C_RO, 1'b0);
        v = W'(rnd());
        wr_chk(`HRP_ADDR_DATA, {24'h0, v}, 1'b0);
        wait_pulse(1'b0);
        `CHK({pin_out, pin_oe}, {8'h00, exp_oe(1'b1, v, 8'h00, 1'b0)})
        c = W'(rnd());
        @(posedge pclk);
        narrow_claim <= c;
        @(negedge pclk);
        `CHK(pin_oe, exp_oe(1'b1, v, c, 1'b0))
        @(posedge pclk);
        link_active <= 1'b1;
        @(negedge pclk);
        `CHK(pin_oe, exp_oe(1'b1, v, c, 1'b1))
        @(posedge pclk);
        {link_active, narrow_claim} <= '0;
        // input side: sampling held until the pins match the condition
        ext_val <= ~c;
        ext_en <= 1'b1;
        wr_chk(`HRP_ADDR_COND, {24'h0, c}, 1'b0);
        wr_chk(`HRP_ADDR_CTRL, C_EN | C_CE, 1'b0);
        repeat (20) @(posedge pclk);
        `CHK(pin_oe, 8'h00)
        rd_chk(`HRP_ADDR_STATUS, 32'h2, 32'h3, 1'b0);
        ext_val <= c;
        wait_pulse(1'b1);
        rdy_level <= 1'b0;
        rd_chk(`HRP_ADDR_DATA, {24'h0, c}, 32'hff, 1'b0);
        wr_chk(`HRP_ADDR_CTRL, C_EN | C_RI, 1'b0);
        for (int i = 0; i < 4; i++)
            rd_chk(`HRP_ADDR_DATA, {24'h0, c}, 32'hff, 1'b0);
        rd_chk(`HRP_ADDR_DATA, 32'h0, 32'h0, 1'b1);
        v = W'(rnd());
        ext_val <= v;
        repeat (4) @(posedge pclk);
        rd_chk(`HRP_ADDR_STATUS, 32'h2, 32'h3, 1'b0);
        rdy_level <= 1'b1;
        wait_pulse(1'b1);
        rd_chk(`HRP_ADDR_DATA, {24'h0, v}, 32'hff, 1'b0);
        `CHK(slow, 0)
        conclude();
    end
endmodule

`default_nettype wire
